/* File: dv/compare_pwm_output_unit_tb.sv */
// self-checking bench for the compare/pwm output unit
`timescale 1ns/1ps
module compare_pwm_output_unit_tb;
    import cpo_pkg::*;
    logic        clk;
    logic        rst;
    logic        slp;
    logic [7:0]  pa;
    logic        ps;
    logic        pe;
    logic        pw;
    logic [31:0] wd;
    logic [31:0] prd;
    logic        rdy;
    logic        serr;
    logic        pin_a;
    logic        oe_a_n;
    logic        pin_b;
    logic        oe_b_n;
    logic        lvl;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [31:0] rd;
    logic        err;
    logic [31:0] c;
    int          errors;
    int          checks_done;
    // design and the load on its default pin
    cpo_pwm_top dut (.clock_in(clk), .reset_in(rst), .sleep_in(slp), .paddr_in(pa), .psel_in(ps),
        .penable_in(pe), .pwrite_in(pw), .pwdata_in(wd), .pstrb_in(4'hf), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(serr), .pin_a_out(pin_a), .pin_a_oe_n_out(oe_a_n),
        .pin_b_out(pin_b), .pin_b_oe_n_out(oe_b_n));
    cpo_load_model load (.clock_in(clk), .pin_in(pin_a), .oe_n_in(oe_a_n), .level_out(lvl),
        .high_len_out(hi_len), .period_len_out(per_len));
    // 100 mhz clock
    always #5 clk = ~clk;
    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, idle cycle first, read data taken at the completing edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        pa <= a;
        pw <= w;
        wd <= d;
        ps <= 1'b1;
        @(posedge clk);
        pe <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        rd = prd;
        err = serr;
        if (n == 16) errors++;
        ps <= 1'b0;
        pe <= 1'b0;
    endtask : apb
    // write and read helpers
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        check(rd, e);
    endtask : rd_chk
    // clocks the line spends high within a window
    task count_hi(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            c += lvl;
        end
    endtask : count_hi
    // reset values and loose bits
    task t_reset;
        check(pin_a, 1'b0);
        check(oe_a_n & oe_b_n, 1'b1);
        rd_chk(CPO_CTRL_OFS, CPO_CTRL_RST);
        rd_chk(CPO_DUTY_HI_OFS, CPO_DUTY_RST);
        rd_chk(CPO_PERIOD_OFS, CPO_PERIOD_RST);
        rd_chk(CPO_ALT_OFS, CPO_ALT_RST);
        wr(CPO_TCTRL_OFS, 32'hffff_fff8);
        rd_chk(CPO_TCTRL_OFS, 32'h0);
        wr(CPO_DIR_OFS, 32'hffff_ffff);
        rd_chk(CPO_DIR_OFS, 32'h1);
        wr(CPO_COUNT_OFS, 32'h55);
        rd_chk(CPO_COUNT_OFS, 32'h0);
        apb(8'h20, 1'b0, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b1);
    endtask : t_reset
    // period 3, duty 1:2 = 6, prescale 1:1 then 1:4
    task t_pwm;
        wr(CPO_PERIOD_OFS, 32'h3);
        wr(CPO_DUTY_LO_OFS, 32'h1);
        wr(CPO_CTRL_OFS, 32'h2c);
        wr(CPO_TCTRL_OFS, 32'h4);
        count_hi(40);
        check({oe_a_n, c[7:0]}, 9'h100);
        wr(CPO_DIR_OFS, 32'h0);
        repeat (48) @(posedge clk);
        check({hi_len, per_len}, {16'd6, 16'd16});
        rd_chk(CPO_DUTY_HI_OFS, 32'h1);
        wr(CPO_DUTY_HI_OFS, 32'h77);
        rd_chk(CPO_DUTY_HI_OFS, 32'h1);
        wr(CPO_TCTRL_OFS, 32'h5);
        repeat (150) @(posedge clk);
        check({hi_len, per_len}, {16'd24, 16'd64});
    endtask : t_pwm
    // zero and full-scale duty, then sleep
    task t_ends;
        wr(CPO_TCTRL_OFS, 32'h4);
        wr(CPO_DUTY_LO_OFS, 32'h0);
        wr(CPO_CTRL_OFS, 32'h0c);
        repeat (20) @(posedge clk);
        count_hi(32);
        check(c, 0);
        wr(CPO_DUTY_LO_OFS, 32'h4);
        repeat (20) @(posedge clk);
        count_hi(32);
        check(c, 32);
        @(posedge clk);
        slp <= 1'b1;
        apb(CPO_COUNT_OFS, 1'b0, 32'h0);
        c = rd;
        repeat (20) @(posedge clk);
        rd_chk(CPO_COUNT_OFS, c);
        check(lvl, 1'b1);
        slp <= 1'b0;
    endtask : t_ends
    // alternate location, then release of the pin
    task t_alt;
        wr(CPO_ALT_OFS, 32'h1);
        @(posedge clk);
        check({oe_a_n, oe_b_n, pin_b}, 3'b101);
        wr(CPO_ALT_OFS, 32'h0);
        wr(CPO_CTRL_OFS, 32'h0);
        @(posedge clk);
        #1;
        check({oe_a_n, pin_a}, 2'b10);
    endtask : t_alt
    // verdict
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        slp = 1'b0;
        pa = 8'h0;
        ps = 1'b0;
        pe = 1'b0;
        pw = 1'b0;
        wd = 32'h0;
        errors = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_pwm;
        t_ends;
        t_alt;
        tally_and_finish;
    end
    // watchdog well past the expected few hundred cycles
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule : compare_pwm_output_unit_tb

/* File: dv/cpo_load_model.sv */
// load on the channel pin: resolves the line and measures pulses
`timescale 1ns/1ps
module cpo_load_model (
    // clock
    input  wire logic        clock_in,
    // pin side
    input  wire logic        pin_in,
    input  wire logic        oe_n_in,
    // measured waveform
    output logic             level_out,
    output logic      [15:0] high_len_out,
    output logic      [15:0] period_len_out
);
    logic        prev;
    logic [15:0] run;
    logic [15:0] hrun;
    // a pull-down holds the line low while nobody drives it
    assign level_out = oe_n_in ? 1'b0 : pin_in;
    // start from a quiet line
    initial begin
        prev = 1'b0;
        run = 16'h0;
        hrun = 16'h0;
        high_len_out = 16'h0;
        period_len_out = 16'h0;
    end
    // clocks between rising edges, and clocks spent high
    always @(posedge clock_in) begin
        prev <= level_out;
        if (level_out && !prev) begin
            period_len_out <= run;
            run <= 16'h1;
        end else begin
            run <= run + 16'h1;
        end
        if (level_out) begin
            hrun <= prev ? hrun + 16'h1 : 16'h1;
        end
        if (!level_out && prev) begin
            high_len_out <= hrun;
        end
    end
endmodule : cpo_load_model

/* File: verilog/cpo_pkg.sv */
// constants and register map for the compare/pwm output unit
// Notes on behaviour
// - timer base freezes while system clock sleeps
// - pin routes to alternate location by select
// - standard pwm waveform, up to 10 bits
// - only period, timer, duty, control steer pwm
// - pin driven only when direction bit output
// - zero control register releases pin, clears latch
// - unimplemented bits read zero, ignore writes
// - zero duty always off, full scale on
// - high level is on, pulse width
// - period match clears timer, sets pin, latches
// - duty is low byte plus two control bits
// - time base equal latched duty clears pin
// - duty high byte read-only during pwm
package cpo_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CPO_CTRL_OFS      = 8'h00;
    localparam logic [7:0] CPO_DUTY_LO_OFS   = 8'h04;
    localparam logic [7:0] CPO_DUTY_HI_OFS   = 8'h08;
    localparam logic [7:0] CPO_PERIOD_OFS    = 8'h0c;
    localparam logic [7:0] CPO_TCTRL_OFS     = 8'h10;
    localparam logic [7:0] CPO_DIR_OFS       = 8'h14;
    localparam logic [7:0] CPO_ALT_OFS       = 8'h18;
    localparam logic [7:0] CPO_COUNT_OFS     = 8'h1c;
    // channel control fields
    localparam int         CPO_MODE_LSB      = 0;
    localparam int         CPO_DLOW_LSB      = 4;
    localparam logic [1:0] CPO_PWM_MODE      = 2'h3;
    // timer control fields
    localparam int         CPO_PRE_LSB       = 0;
    localparam int         CPO_TON_BIT       = 2;
    localparam logic [1:0] CPO_PRE_1         = 2'h0;
    localparam logic [1:0] CPO_PRE_4         = 2'h1;
    // prescaler terminal counts, four clocks per timer step at 1:1
    localparam logic [5:0] CPO_TOP_1         = 6'h03;
    localparam logic [5:0] CPO_TOP_4         = 6'h0f;
    localparam logic [5:0] CPO_TOP_16        = 6'h3f;
    // reset values
    localparam logic [7:0] CPO_CTRL_RST      = 8'h00;
    localparam logic [7:0] CPO_DUTY_RST      = 8'h00;
    localparam logic [7:0] CPO_PERIOD_RST    = 8'hff;
    localparam logic [2:0] CPO_TCTRL_RST     = 3'h0;
    localparam logic       CPO_DIR_RST       = 1'b1;
    localparam logic       CPO_ALT_RST       = 1'b0;
endpackage : cpo_pkg

/* File: verilog/cpo_pwm_top.sv */
// apb register file and standard pwm output logic for one channel
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cpo_pwm_top
    import cpo_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    // power state
    input  wire logic        sleep_in,
    // apb slave
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // channel output pin, default location
    output logic             pin_a_out,
    output logic             pin_a_oe_n_out,
    // channel output pin, alternate location
    output logic             pin_b_out,
    output logic             pin_b_oe_n_out
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] duty_lo;
        logic [7:0] duty_hi;
        logic [1:0] low_latch;
        logic [7:0] period;
        logic [2:0] tctrl;
        logic       dir;
        logic       alt;
        logic       pin;
        logic [7:0] rdata;
        logic       err;
    } cpo_state_t;

    cpo_state_t state_reg;
    cpo_state_t state_next;
    logic [7:0] count;
    logic [9:0] time_base;
    logic       rollover;
    logic       pwm_on;
    logic       run;
    logic       setup;
    logic       wr;
    logic       drive;
    logic [9:0] duty_new;
    logic [9:0] duty_act;

    // pwm mode decode from the mode select field
    function automatic logic cpo_is_pwm(input logic [7:0] ctrl);
        cpo_is_pwm = (ctrl[CPO_MODE_LSB+3 -: 2] == CPO_PWM_MODE);
    endfunction : cpo_is_pwm

    // address decode, true for a mapped offset
    function automatic logic cpo_mapped(input logic [7:0] addr);
        case (addr)
            CPO_CTRL_OFS, CPO_DUTY_LO_OFS, CPO_DUTY_HI_OFS, CPO_PERIOD_OFS,
            CPO_TCTRL_OFS, CPO_DIR_OFS, CPO_ALT_OFS, CPO_COUNT_OFS: cpo_mapped = 1'b1;
            default: cpo_mapped = 1'b0;
        endcase
    endfunction : cpo_mapped

    // control decode
    assign pwm_on   = cpo_is_pwm(state_reg.ctrl);
    assign run      = state_reg.tctrl[CPO_TON_BIT] && !sleep_in;
    assign setup    = psel_in && !penable_in;
    assign wr       = psel_in && penable_in && pwrite_in && pstrb_in[0];
    assign duty_new = {state_reg.duty_lo, state_reg.ctrl[CPO_DLOW_LSB+1 -: 2]};
    assign duty_act = {state_reg.duty_hi, state_reg.low_latch};

    // time base from period register, timer control and sleep input
    cpo_time_base u_time_base (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .run_in        (run),
        .prescale_in   (state_reg.tctrl[CPO_PRE_LSB+1 -: 2]),
        .period_in     (state_reg.period),
        .count_out     (count),
        .time_base_out (time_base),
        .rollover_out  (rollover)
    );

    // register writes, duty latch, output latch and read capture
    always_comb begin
        state_next = state_reg;
        // software writes, low byte lane only
        if (wr) begin
            case (paddr_in)
                CPO_CTRL_OFS:    state_next.ctrl    = pwdata_in[7:0];
                CPO_DUTY_LO_OFS: state_next.duty_lo = pwdata_in[7:0];
                CPO_DUTY_HI_OFS: begin
                    if (!pwm_on) begin
                        state_next.duty_hi = pwdata_in[7:0];
                    end
                end
                CPO_PERIOD_OFS:  state_next.period  = pwdata_in[7:0];
                CPO_TCTRL_OFS:   state_next.tctrl   = pwdata_in[2:0];
                CPO_DIR_OFS:     state_next.dir     = pwdata_in[0];
                CPO_ALT_OFS:     state_next.alt     = pwdata_in[0];
                default:         state_next.ctrl    = state_reg.ctrl;
            endcase
        end
        // pwm engine: period rollover wins over the duty match
        if (!pwm_on) begin
            state_next.pin = 1'b0;
        end else if (rollover) begin
            state_next.duty_hi   = state_reg.duty_lo;
            state_next.low_latch = state_reg.ctrl[CPO_DLOW_LSB+1 -: 2];
            state_next.pin       = (duty_new != 10'h000);
        end else if (time_base == duty_act) begin
            state_next.pin = 1'b0;
        end
        // read data captured in the setup phase
        if (setup) begin
            state_next.err = !cpo_mapped(paddr_in);
            case (paddr_in)
                CPO_CTRL_OFS:    state_next.rdata = state_reg.ctrl;
                CPO_DUTY_LO_OFS: state_next.rdata = state_reg.duty_lo;
                CPO_DUTY_HI_OFS: state_next.rdata = state_reg.duty_hi;
                CPO_PERIOD_OFS:  state_next.rdata = state_reg.period;
                CPO_TCTRL_OFS:   state_next.rdata = {5'h00, state_reg.tctrl};
                CPO_DIR_OFS:     state_next.rdata = {7'h00, state_reg.dir};
                CPO_ALT_OFS:     state_next.rdata = {7'h00, state_reg.alt};
                CPO_COUNT_OFS:   state_next.rdata = count;
                default:         state_next.rdata = 8'h00;
            endcase
        end
    end

    // state register with reset defaults
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_reg.ctrl      <= CPO_CTRL_RST;
            state_reg.duty_lo   <= CPO_DUTY_RST;
            state_reg.duty_hi   <= CPO_DUTY_RST;
            state_reg.low_latch <= 2'h0;
            state_reg.period    <= CPO_PERIOD_RST;
            state_reg.tctrl     <= CPO_TCTRL_RST;
            state_reg.dir       <= CPO_DIR_RST;
            state_reg.alt       <= CPO_ALT_RST;
            state_reg.pin       <= 1'b0;
            state_reg.rdata     <= 8'h00;
            state_reg.err       <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // apb answer, zero wait states
    assign pready_out  = 1'b1;
    assign prdata_out  = {24'h000000, state_reg.rdata};
    assign pslverr_out = psel_in && penable_in && state_reg.err;

    // pin drive: pwm mode, direction output, selected location
    assign drive          = pwm_on && !state_reg.dir;
    assign pin_a_out      = state_reg.pin;
    assign pin_b_out      = state_reg.pin;
    assign pin_a_oe_n_out = !(drive && !state_reg.alt);
    assign pin_b_oe_n_out = !(drive && state_reg.alt);

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    // period rollover with nonzero duty raises the pin
    sequence roll_nonzero_s;
        pwm_on && rollover && duty_new != 10'h000;
    endsequence
    sequence roll_zero_s;
        pwm_on && rollover && duty_new == 10'h000;
    endsequence

    rollover_sets_pin_a: assert property (roll_nonzero_s |=> state_reg.pin)
        else $error("pin not set at period rollover");
    zero_duty_low_a: assert property (roll_zero_s |=> !state_reg.pin ##1 !state_reg.pin)
        else $error("zero duty produced a pulse");
    duty_match_clears_a: assert property (pwm_on && !rollover && time_base == duty_act
                                          |=> !state_reg.pin)
        else $error("duty match did not clear pin");
    duty_latched_a: assert property (pwm_on && rollover |=> duty_act == $past(duty_new))
        else $error("duty not latched at rollover");
    control_release_a: assert property (state_reg.ctrl == 8'h00
                                        |-> pin_a_oe_n_out && pin_b_oe_n_out ##1 !state_reg.pin)
        else $error("pin not released with control cleared");
    direction_gates_a: assert property (state_reg.dir |-> pin_a_oe_n_out && pin_b_oe_n_out)
        else $error("pin driven while direction is input");
    alt_location_a: assert property (drive |-> (pin_a_oe_n_out != pin_b_oe_n_out)
                                     && (pin_b_oe_n_out == !state_reg.alt))
        else $error("wrong pin location driven");
    duty_hi_locked_a: assert property (pwm_on && !rollover && wr && paddr_in == CPO_DUTY_HI_OFS
                                       |=> $stable(state_reg.duty_hi))
        else $error("duty high byte written during pwm");
    unused_bits_a: assert property (setup && (paddr_in == CPO_TCTRL_OFS || paddr_in == CPO_DIR_OFS)
                                    |=> prdata_out[31:3] == 29'h0000000)
        else $error("unimplemented bits read nonzero");
    reset_defaults_a: assert property (@(posedge clock_in) disable iff (1'b0)
                                       reset_in |=> !state_reg.pin && state_reg.dir
                                       && state_reg.ctrl == CPO_CTRL_RST)
        else $error("reset did not restore defaults");
    sleep_holds_a: assert property (sleep_in && !wr |=> $stable(count))
        else $error("timer moved during sleep");
endmodule : cpo_pwm_top

/* File: verilog/cpo_time_base.sv */
// prescaler and 8-bit period timer forming the 10-bit time base
`timescale 1ns/1ps
module cpo_time_base
    import cpo_pkg::*;
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    // control
    input  wire logic       run_in,
    input  wire logic [1:0] prescale_in,
    input  wire logic [7:0] period_in,
    // time base
    output logic      [7:0] count_out,
    output logic      [9:0] time_base_out,
    output logic            rollover_out
);
    typedef struct packed {
        logic [5:0] pre;
        logic [7:0] count;
    } cpo_tb_state_t;

    cpo_tb_state_t state_reg;
    cpo_tb_state_t state_next;
    logic [5:0]    top;
    logic          step;

    // terminal count of the prescaler for the selected ratio
    function automatic logic [5:0] cpo_pre_top(input logic [1:0] code);
        case (code)
            CPO_PRE_1: cpo_pre_top = CPO_TOP_1;
            CPO_PRE_4: cpo_pre_top = CPO_TOP_4;
            default:   cpo_pre_top = CPO_TOP_16;
        endcase
    endfunction : cpo_pre_top

    // step and rollover decode
    assign top          = cpo_pre_top(prescale_in);
    assign step         = run_in && (state_reg.pre >= top);
    assign rollover_out = step && (state_reg.count == period_in);

    // next state: timer clears on the step after it equals period
    always_comb begin
        state_next = state_reg;
        if (run_in) begin
            state_next.pre = step ? 6'h00 : state_reg.pre + 6'h01;
            if (rollover_out) begin
                state_next.count = 8'h00;
            end else if (step) begin
                state_next.count = state_reg.count + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // time base as it stands after the coming edge, so a registered pin
    // falls in the very clock in which the timer reaches the duty value
    always_comb begin
        case (prescale_in)
            CPO_PRE_1: time_base_out = {state_next.count, state_next.pre[1:0]};
            CPO_PRE_4: time_base_out = {state_next.count, state_next.pre[3:2]};
            default:   time_base_out = {state_next.count, state_next.pre[5:4]};
        endcase
    end
    assign count_out = state_reg.count;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    frozen_when_idle_a: assert property (!run_in |=> $stable(state_reg))
        else $error("time base moved while stopped");
    timer_clears_a: assert property (rollover_out |=> count_out == 8'h00)
        else $error("timer not cleared after period match");
endmodule : cpo_time_base
